// ===== logic/fpm_debounce.sv
// Button synchroniser and debouncer giving one pulse per press.
`timescale 1ns/1ps
module fpm_debounce #(
  parameter int DEB_CYC = fpm_pkg::DEB_CYC
) (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_btn,
  output logic o_press
);
  logic sync1_ff;
  logic sync2_ff;
  logic stable_ff;
  logic press_ff;
  logic [21:0] cnt_ff;

  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      sync1_ff <= 1'b0;
      sync2_ff <= 1'b0;
    end
    else
    begin
      sync1_ff <= i_btn;
      sync2_ff <= sync1_ff;
    end
  end

  // The new level is accepted only after it has held for the whole window.
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      cnt_ff <= 22'h000000;
      stable_ff <= 1'b0;
      press_ff <= 1'b0;
    end
    else
    begin
      press_ff <= 1'b0;
      if (sync2_ff == stable_ff)
        cnt_ff <= 22'h000000;
      else if (cnt_ff == 22'(DEB_CYC - 1))
      begin
        cnt_ff <= 22'h000000;
        stable_ff <= sync2_ff;
        press_ff <= sync2_ff;
      end
      else
        cnt_ff <= cnt_ff + 22'h000001;
    end
  end

  assign o_press = press_ff;
endmodule

// ===== logic/fpm_front_panel.sv
// Front-panel menu, monitor and editing controller for a 128x32 display.
// How it works
// - Drives 128x32 panel, buttons back up down forward.
// - Any press lights backlight for 90 seconds.
// - Back: menu, monitor, parent, digit left.
// - Up: previous page, cursor up, digit plus one.
// - Down: next page, cursor down, digit minus one.
// - Forward: menu, select item, digit right.
// - Marker at left; scroll bar above three items.
// - Forward on number edits; underline selected digit.
// - Forward on last digit: next part or finish.
// - Digit changes carry and borrow across number.
// - Cycling mode default with fixed page order.
// - Each page holds for the cycle delay (ten seconds after reset), then advances.
// - Up/down step pages; cycling resumes after hold-off.
// - Single pages name over value; multi pages listed.
// - Power factor pages show quadrant, load, lag icons.
// - Frequency pages show measured phase icon.
// - Line-to-line pages show phase angle.
// - List mode has four fixed category lists.
// - List mode: scroll, next/previous list, menu at ends.
// - Forward on first preference toggles monitor mode.
`timescale 1ns/1ps
module fpm_front_panel #(
  parameter int MS_CYC = fpm_pkg::MS_CYC,
  parameter int DEB_CYC = fpm_pkg::DEB_CYC
) (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_btn_back,
  input wire logic i_btn_up,
  input wire logic i_btn_down,
  input wire logic i_btn_fwd,
  output logic o_backlight,
  output fpm_pkg::fpm_scr_t o_screen,
  output fpm_pkg::fpm_mon_t o_monitor_mode,
  output logic [3:0] o_page,
  output logic o_page_multi,
  output fpm_pkg::fpm_corner_t o_corner,
  output logic [1:0] o_list_idx,
  output logic [2:0] o_list_row,
  output logic [3:0] o_menu_cursor,
  output logic [1:0] o_marker_row,
  output logic o_scroll_show,
  output logic o_edit_active,
  output logic [1:0] o_edit_digit,
  output logic [1:0] o_edit_part,
  output logic [13:0] o_edit_val,
  output logic [13:0] o_cycle_delay,
  output logic [13:0] o_cycle_resume
);
  logic [3:0] btn_raw;
  logic [3:0] btn_press;
  logic ev_back;
  logic ev_up;
  logic ev_down;
  logic ev_fwd;
  logic ev_any;
  logic [17:0] ms_cnt_ff;
  logic [9:0] sec_cnt_ff;
  logic ms_tick;
  logic sec_tick;
  logic bl_on_ff;
  logic [6:0] bl_cnt_ff;
  logic [13:0] dwell_ff;
  logic [13:0] hold_ff;
  logic auto_adv;
  logic cyc_on;
  fpm_pkg::fpm_scr_t scr_ff;
  fpm_pkg::fpm_mon_t mode_ff;
  logic [3:0] page_ff;
  logic [1:0] list_ff;
  logic [2:0] row_ff;
  logic [3:0] cursor_ff;
  logic [3:0] top_ff;
  logic [1:0] part_ff;
  logic [2:0] fld_idx_ff;
  logic [13:0] fld_ff [fpm_pkg::N_FLD];
  logic is_menu;
  logic [3:0] len;
  logic page_multi_ff;
  fpm_pkg::fpm_corner_t corner_ff;
  logic [1:0] marker_ff;
  logic scroll_ff;
  logic ed_start;
  logic ed_end;
  logic ed_last;
  logic ed_load;
  logic [13:0] ed_load_val;
  logic ed_in_edit;
  logic [13:0] ed_val;
  logic [1:0] ed_digit;
  logic edit_ff;

  function automatic logic [3:0] menu_len(input fpm_pkg::fpm_scr_t s);
    case (s)
      fpm_pkg::SCR_MAIN: menu_len = fpm_pkg::N_MAIN;
      fpm_pkg::SCR_CFG: menu_len = fpm_pkg::N_CFG;
      fpm_pkg::SCR_PREF: menu_len = fpm_pkg::N_PREF;
      fpm_pkg::SCR_EDIT: menu_len = fpm_pkg::N_PREF;
      default: menu_len = 4'h0;
    endcase
  endfunction

  assign btn_raw = {i_btn_fwd, i_btn_down, i_btn_up, i_btn_back};

  genvar gi;
  generate
    for (gi = 0; gi < fpm_pkg::N_BTN; gi++)
    begin : g_btn
      fpm_debounce #(.DEB_CYC(DEB_CYC)) u_deb (
        .i_clk_sys(i_clk_sys),
        .i_rst(i_rst),
        .i_btn(btn_raw[gi]),
        .o_press(btn_press[gi])
      );
    end
  endgenerate

  // Presses in the same cycle resolve left to right into a single event.
  assign ev_back = btn_press[fpm_pkg::BTN_BACK];
  assign ev_up = btn_press[fpm_pkg::BTN_UP] && !ev_back;
  assign ev_down = btn_press[fpm_pkg::BTN_DOWN] && !ev_back && !ev_up;
  assign ev_fwd = btn_press[fpm_pkg::BTN_FWD] && !ev_back && !ev_up && !ev_down;
  assign ev_any = |btn_press;

  assign ms_tick = ms_cnt_ff == 18'(MS_CYC - 1);
  assign sec_tick = ms_tick && sec_cnt_ff == fpm_pkg::SEC_LAST_MS;

  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst || ms_tick)
      ms_cnt_ff <= 18'h00000;
    else
      ms_cnt_ff <= ms_cnt_ff + 18'h00001;
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst || sec_tick)
      sec_cnt_ff <= 10'h000;
    else if (ms_tick)
      sec_cnt_ff <= sec_cnt_ff + 10'h001;
  end

  // Backlight on at any press, off when the seconds count runs out.
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      bl_on_ff <= 1'b0;
      bl_cnt_ff <= 7'h00;
    end
    else if (ev_any)
    begin
      bl_on_ff <= 1'b1;
      bl_cnt_ff <= fpm_pkg::BL_S;
    end
    else if (sec_tick && bl_on_ff)
    begin
      bl_cnt_ff <= bl_cnt_ff - 7'h01;
      if (bl_cnt_ff == 7'h01)
        bl_on_ff <= 1'b0;
    end
  end

  assign cyc_on = scr_ff == fpm_pkg::SCR_MON && mode_ff == fpm_pkg::MON_CYCLE;
  assign auto_adv = cyc_on && sec_tick && hold_ff == 14'h0000
                    && dwell_ff + 14'h0001 >= fld_ff[fpm_pkg::FLD_DELAY];

  // Page dwell and manual hold-off, both counted in seconds.
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      dwell_ff <= 14'h0000;
      hold_ff <= 14'h0000;
    end
    else if (cyc_on && (ev_up || ev_down))
    begin
      dwell_ff <= 14'h0000;
      hold_ff <= fld_ff[fpm_pkg::FLD_RESUME];
    end
    else if (sec_tick)
    begin
      if (hold_ff != 14'h0000)
        hold_ff <= hold_ff - 14'h0001;
      else if (auto_adv)
        dwell_ff <= 14'h0000;
      else
        dwell_ff <= dwell_ff + 14'h0001;
    end
  end

  assign is_menu = scr_ff == fpm_pkg::SCR_MAIN || scr_ff == fpm_pkg::SCR_CFG
                   || scr_ff == fpm_pkg::SCR_PREF;
  assign len = menu_len(scr_ff);
  assign ed_in_edit = scr_ff == fpm_pkg::SCR_EDIT;
  assign ed_start = scr_ff == fpm_pkg::SCR_PREF && ev_fwd && cursor_ff != fpm_pkg::PREF_MODE;
  assign ed_last = (cursor_ff == fpm_pkg::PREF_TIME) ? part_ff == fpm_pkg::TIME_LAST_PART : 1'b1;
  assign ed_load = ed_start || (ed_in_edit && ed_end && !ed_last);
  assign ed_load_val = ed_start ? fld_ff[3'(cursor_ff - 4'h1)] : fld_ff[fld_idx_ff + 3'h1];

  // Screen navigation for monitor, list and menus.
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      scr_ff <= fpm_pkg::SCR_MON;
      mode_ff <= fpm_pkg::MON_CYCLE;
      page_ff <= 4'h0;
      list_ff <= 2'h0;
      row_ff <= 3'h0;
      cursor_ff <= 4'h0;
      part_ff <= 2'h0;
      fld_idx_ff <= 3'h0;
    end
    else
    begin
      if (is_menu && ev_up && cursor_ff != 4'h0)
        cursor_ff <= cursor_ff - 4'h1;
      if (is_menu && ev_down && cursor_ff != len - 4'h1)
        cursor_ff <= cursor_ff + 4'h1;
      case (scr_ff)
        fpm_pkg::SCR_MON:
          if (mode_ff == fpm_pkg::MON_CYCLE)
          begin
            if (ev_back || ev_fwd)
            begin
              scr_ff <= fpm_pkg::SCR_MAIN;
              cursor_ff <= 4'h0;
            end
            else if (ev_up)
              page_ff <= (page_ff == 4'h0) ? fpm_pkg::PG_LAST : page_ff - 4'h1;
            else if (ev_down || auto_adv)
              page_ff <= (page_ff == fpm_pkg::PG_LAST) ? 4'h0 : page_ff + 4'h1;
          end
          else
          begin
            if (ev_up && row_ff != 3'h0)
              row_ff <= row_ff - 3'h1;
            else if (ev_down && row_ff != fpm_pkg::ROW_LAST)
              row_ff <= row_ff + 3'h1;
            else if ((ev_fwd && list_ff == fpm_pkg::LIST_LAST) || (ev_back && list_ff == 2'h0))
            begin
              scr_ff <= fpm_pkg::SCR_MAIN;
              cursor_ff <= 4'h0;
            end
            else if (ev_fwd || ev_back)
            begin
              list_ff <= ev_fwd ? list_ff + 2'h1 : list_ff - 2'h1;
              row_ff <= 3'h0;
            end
          end
        fpm_pkg::SCR_MAIN:
          if (ev_back)
            scr_ff <= fpm_pkg::SCR_MON;
          else if (ev_fwd && cursor_ff == fpm_pkg::MAIN_CFG)
          begin
            scr_ff <= fpm_pkg::SCR_CFG;
            cursor_ff <= 4'h0;
          end
        fpm_pkg::SCR_CFG:
          if (ev_back)
          begin
            scr_ff <= fpm_pkg::SCR_MAIN;
            cursor_ff <= fpm_pkg::MAIN_CFG;
          end
          else if (ev_fwd && cursor_ff == fpm_pkg::CFG_DISP)
          begin
            scr_ff <= fpm_pkg::SCR_PREF;
            cursor_ff <= 4'h0;
          end
        fpm_pkg::SCR_PREF:
          if (ev_back)
          begin
            scr_ff <= fpm_pkg::SCR_CFG;
            cursor_ff <= fpm_pkg::CFG_DISP;
          end
          else if (ev_fwd && cursor_ff == fpm_pkg::PREF_MODE)
          begin
            mode_ff <= (mode_ff == fpm_pkg::MON_CYCLE) ? fpm_pkg::MON_LIST : fpm_pkg::MON_CYCLE;
            list_ff <= 2'h0;
            row_ff <= 3'h0;
          end
          else if (ed_start)
          begin
            scr_ff <= fpm_pkg::SCR_EDIT;
            part_ff <= 2'h0;
            fld_idx_ff <= 3'(cursor_ff - 4'h1);
          end
        fpm_pkg::SCR_EDIT:
          if (ed_end && ed_last)
            scr_ff <= fpm_pkg::SCR_PREF;
          else if (ed_end)
          begin
            part_ff <= part_ff + 2'h1;
            fld_idx_ff <= fld_idx_ff + 3'h1;
          end
        default: scr_ff <= fpm_pkg::SCR_MON;
      endcase
    end
  end

  // Edit flag kept in a register so the output comes straight from a flop.
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
      edit_ff <= 1'b0;
    else if (ed_start)
      edit_ff <= 1'b1;
    else if (ed_in_edit && ed_end && ed_last)
      edit_ff <= 1'b0;
  end

  // Finished parts are written back to their field.
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      fld_ff[fpm_pkg::FLD_DELAY] <= fpm_pkg::CYC_S_DEF;
      fld_ff[fpm_pkg::FLD_RESUME] <= fpm_pkg::HOLD_S_DEF;
      for (int k = 2; k < fpm_pkg::N_FLD; k++)
        fld_ff[k] <= fpm_pkg::TIME_DEF;
    end
    else if (ed_in_edit && ed_end)
      fld_ff[fld_idx_ff] <= ed_val;
  end

  fpm_num_edit u_edit (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_load(ed_load),
    .i_load_val(ed_load_val),
    .i_left(ed_in_edit && ev_back),
    .i_right(ed_in_edit && ev_fwd),
    .i_inc(ed_in_edit && ev_up),
    .i_dec(ed_in_edit && ev_down),
    .o_val(ed_val),
    .o_digit(ed_digit),
    .o_part_end(ed_end)
  );

  // Three visible rows follow the cursor.
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst || !(is_menu || ed_in_edit))
      top_ff <= 4'h0;
    else if (cursor_ff < top_ff)
      top_ff <= cursor_ff;
    else if (cursor_ff > top_ff + fpm_pkg::MENU_ROWS - 4'h1)
      top_ff <= cursor_ff - fpm_pkg::MENU_ROWS + 4'h1;
  end

  // Page layout, corner icon, marker row and scroll bar.
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      page_multi_ff <= 1'b0;
      corner_ff <= fpm_pkg::CRN_NONE;
      marker_ff <= 2'h0;
      scroll_ff <= 1'b0;
    end
    else
    begin
      page_multi_ff <= page_ff >= fpm_pkg::PG_MULTI;
      if (page_ff == fpm_pkg::PG_PF_AVG || page_ff == fpm_pkg::PG_PF_PH)
        corner_ff <= fpm_pkg::CRN_PF;
      else if (page_ff == fpm_pkg::PG_FREQ)
        corner_ff <= fpm_pkg::CRN_FREQ;
      else if (page_ff == fpm_pkg::PG_VLL)
        corner_ff <= fpm_pkg::CRN_ANGLE;
      else
        corner_ff <= fpm_pkg::CRN_NONE;
      marker_ff <= 2'(cursor_ff - top_ff);
      scroll_ff <= len > fpm_pkg::MENU_ROWS;
    end
  end

  assign o_backlight = bl_on_ff;
  assign o_screen = scr_ff;
  assign o_monitor_mode = mode_ff;
  assign o_page = page_ff;
  assign o_page_multi = page_multi_ff;
  assign o_corner = corner_ff;
  assign o_list_idx = list_ff;
  assign o_list_row = row_ff;
  assign o_menu_cursor = cursor_ff;
  assign o_marker_row = marker_ff;
  assign o_scroll_show = scroll_ff;
  assign o_edit_active = edit_ff;
  assign o_edit_digit = ed_digit;
  assign o_edit_part = part_ff;
  assign o_edit_val = ed_val;
  assign o_cycle_delay = fld_ff[fpm_pkg::FLD_DELAY];
  assign o_cycle_resume = fld_ff[fpm_pkg::FLD_RESUME];

  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_rst);

  sequence s_pref_num;
    scr_ff == fpm_pkg::SCR_PREF && cursor_ff == 4'h1 && ev_fwd;
  endsequence
  sequence s_editing;
    scr_ff == fpm_pkg::SCR_EDIT && o_edit_digit == 2'h0;
  endsequence

  property p_bl_on;
    ev_any |=> o_backlight && bl_cnt_ff == fpm_pkg::BL_S;
  endproperty
  a_bl_on: assert property (p_bl_on) else $error("Backlight not lit by press.");
  property p_bl_off;
    bl_on_ff && bl_cnt_ff == 7'h01 && sec_tick && !ev_any |=> !o_backlight;
  endproperty
  a_bl_off: assert property (p_bl_off) else $error("Backlight stayed on.");
  property p_mon_menu;
    cyc_on && (ev_back || ev_fwd) |=> scr_ff == fpm_pkg::SCR_MAIN && cursor_ff == 4'h0;
  endproperty
  a_mon_menu: assert property (p_mon_menu) else $error("Monitor did not open menu.");
  property p_main_back;
    scr_ff == fpm_pkg::SCR_MAIN && ev_back |=> scr_ff == fpm_pkg::SCR_MON;
  endproperty
  a_main_back: assert property (p_main_back) else $error("Back missed monitor.");
  property p_page_up;
    cyc_on && ev_up |=> page_ff == ($past(page_ff) == 4'h0 ? 4'hA : $past(page_ff) - 4'h1);
  endproperty
  a_page_up: assert property (p_page_up) else $error("Up did not step back.");
  property p_page_down;
    cyc_on && ev_down |=> page_ff == ($past(page_ff) == 4'hA ? 4'h0 : $past(page_ff) + 4'h1);
  endproperty
  a_page_down: assert property (p_page_down) else $error("Down did not step on.");
  property p_hold;
    cyc_on && ev_up |=> hold_ff == o_cycle_resume && dwell_ff == 14'h0000;
  endproperty
  a_hold: assert property (p_hold) else $error("Hold-off not armed.");
  property p_scroll;
    scr_ff == fpm_pkg::SCR_CFG |=> o_scroll_show;
  endproperty
  a_scroll: assert property (p_scroll) else $error("Scroll bar missing.");
  property p_edit_enter;
    s_pref_num |=> s_editing ##0 o_edit_val == $past(o_cycle_delay);
  endproperty
  a_edit_enter: assert property (p_edit_enter) else $error("Edit not entered.");
  property p_borrow;
    o_edit_active && o_edit_digit == 2'h3 && ev_down && o_edit_val == 14'h000A
      |=> o_edit_val == 14'h0009;
  endproperty
  a_borrow: assert property (p_borrow) else $error("Borrow wrong.");
  property p_mode;
    scr_ff == fpm_pkg::SCR_PREF && cursor_ff == 4'h0 && ev_fwd |=> mode_ff != $past(mode_ff);
  endproperty
  a_mode: assert property (p_mode) else $error("Mode not toggled.");
  property p_list_first;
    scr_ff == fpm_pkg::SCR_MON && mode_ff == fpm_pkg::MON_LIST && list_ff == 2'h0 && ev_back
      |=> scr_ff == fpm_pkg::SCR_MAIN;
  endproperty
  a_list_first: assert property (p_list_first) else $error("List back missed menu.");
  property p_one_event;
    $onehot0({ev_back, ev_up, ev_down, ev_fwd});
  endproperty
  a_one_event: assert property (p_one_event) else $error("Two events at once.");
endmodule

// ===== logic/fpm_num_edit.sv
// Digit-by-digit editor for one four-digit number part.
`timescale 1ns/1ps
module fpm_num_edit (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_load,
  input wire logic [13:0] i_load_val,
  input wire logic i_left,
  input wire logic i_right,
  input wire logic i_inc,
  input wire logic i_dec,
  output logic [13:0] o_val,
  output logic [1:0] o_digit,
  output logic o_part_end
);
  logic [13:0] val_ff;
  logic [1:0] dig_ff;
  logic end_ff;
  logic [13:0] step;
  logic [13:0] up_sum;

  function automatic logic [13:0] place(input logic [1:0] d);
    case (d)
      2'h0: place = fpm_pkg::PLACE_1000;
      2'h1: place = fpm_pkg::PLACE_100;
      2'h2: place = fpm_pkg::PLACE_10;
      default: place = fpm_pkg::PLACE_1;
    endcase
  endfunction

  assign step = place(dig_ff);
  assign up_sum = val_ff + step;

  // Whole-number add or subtract of the place value, wrapping modulo 10000.
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
      val_ff <= 14'h0000;
    else if (i_load)
      val_ff <= i_load_val;
    else if (i_inc)
      val_ff <= (up_sum >= fpm_pkg::VAL_MOD) ? up_sum - fpm_pkg::VAL_MOD : up_sum;
    else if (i_dec)
      val_ff <= (val_ff < step) ? val_ff + fpm_pkg::VAL_MOD - step : val_ff - step;
  end

  // Underlined digit moves left and right.
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst || i_load)
      dig_ff <= 2'h0;
    else if (i_left && dig_ff != 2'h0)
      dig_ff <= dig_ff - 2'h1;
    else if (i_right)
      dig_ff <= (dig_ff == fpm_pkg::DIG_LAST) ? 2'h0 : dig_ff + 2'h1;
  end

  // Forward on the rightmost digit closes this part.
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
      end_ff <= 1'b0;
    else
      end_ff <= i_right && !i_load && dig_ff == fpm_pkg::DIG_LAST;
  end

  assign o_val = val_ff;
  assign o_digit = dig_ff;
  assign o_part_end = end_ff;
endmodule

// ===== logic/fpm_pkg.sv
// Constants and types shared by the front-panel menu controller.
package fpm_pkg;
  localparam int CLK_NS = 5;
  localparam int MS_NS = 1000000;
  localparam int MS_CYC = MS_NS / CLK_NS;
  localparam int DEB_MS = 10;
  localparam int DEB_CYC = DEB_MS * MS_CYC;
  localparam logic [9:0] SEC_LAST_MS = 10'h3E7;
  localparam int PANEL_W = 128;
  localparam int PANEL_H = 32;
  localparam int N_BTN = 4;
  localparam int BTN_BACK = 0;
  localparam int BTN_UP = 1;
  localparam int BTN_DOWN = 2;
  localparam int BTN_FWD = 3;
  localparam logic [6:0] BL_S = 7'h5A;
  localparam logic [13:0] CYC_S_DEF = 14'h000A;
  localparam logic [13:0] HOLD_S_DEF = 14'h005A;
  localparam logic [13:0] TIME_DEF = 14'h000C;
  localparam logic [13:0] VAL_MOD = 14'h2710;
  localparam logic [13:0] PLACE_1000 = 14'h03E8;
  localparam logic [13:0] PLACE_100 = 14'h0064;
  localparam logic [13:0] PLACE_10 = 14'h000A;
  localparam logic [13:0] PLACE_1 = 14'h0001;
  localparam logic [1:0] DIG_LAST = 2'h3;
  localparam logic [3:0] PG_LAST = 4'hA;
  localparam logic [3:0] PG_PF_AVG = 4'h2;
  localparam logic [3:0] PG_FREQ = 4'h3;
  localparam logic [3:0] PG_MULTI = 4'h4;
  localparam logic [3:0] PG_VLL = 4'h6;
  localparam logic [3:0] PG_PF_PH = 4'hA;
  localparam logic [3:0] N_MAIN = 4'h2;
  localparam logic [3:0] N_CFG = 4'hA;
  localparam logic [3:0] N_PREF = 4'h4;
  localparam logic [3:0] MENU_ROWS = 4'h3;
  localparam logic [3:0] MAIN_CFG = 4'h1;
  localparam logic [3:0] CFG_DISP = 4'h8;
  localparam logic [3:0] PREF_MODE = 4'h0;
  localparam logic [3:0] PREF_TIME = 4'h3;
  localparam logic [2:0] FLD_DELAY = 3'h0;
  localparam logic [2:0] FLD_RESUME = 3'h1;
  localparam int N_FLD = 5;
  localparam logic [1:0] TIME_LAST_PART = 2'h2;
  localparam logic [1:0] LIST_LAST = 2'h3;
  localparam logic [2:0] ROW_LAST = 3'h7;
  typedef enum logic [2:0] {SCR_MON, SCR_MAIN, SCR_CFG, SCR_PREF, SCR_EDIT} fpm_scr_t;
  typedef enum logic {MON_CYCLE, MON_LIST} fpm_mon_t;
  typedef enum logic [1:0] {CRN_NONE, CRN_PF, CRN_FREQ, CRN_ANGLE} fpm_corner_t;
endpackage

// ===== tb/fpm_front_panel_tb_top.sv
// Self-checking bench for the front-panel menu controller.
`timescale 1ns/1ps
module fpm_front_panel_tb_top;
  localparam int MS = 2;
  localparam int DEB = 4;
  localparam int SEC = MS * 1000;
  localparam int BK = 0;
  localparam int UP = 1;
  localparam int DN = 2;
  localparam int FW = 3;
  localparam logic [2:0] MN = 3'h0;
  localparam logic [2:0] MA = 3'h1;
  localparam logic [2:0] CF = 3'h2;
  localparam logic [2:0] PR = 3'h3;
  localparam logic [2:0] ED = 3'h4;
  typedef struct {int b; int n; logic [2:0] s; logic [15:0] v;} fpm_row_t;
  logic clk_sys;
  logic rst;
  logic b_back, b_up, b_down, b_fwd;
  logic backlight, page_multi, scroll_show;
  fpm_pkg::fpm_scr_t screen;
  fpm_pkg::fpm_mon_t monitor_mode;
  fpm_pkg::fpm_corner_t corner;
  logic [3:0] page, menu_cursor;
  logic [1:0] list_idx, edit_digit, marker_row, edit_part;
  logic [2:0] list_row;
  logic edit_active;
  logic [13:0] edit_val, cycle_delay, cycle_resume;
  int miscompares = 0;
  int comparisons = 0;
  fpm_row_t rows [24] = '{
    '{BK, 1, MA, 16'h0000}, '{BK, 1, MN, 16'h0000}, '{FW, 1, MA, 16'h0000},
    '{DN, 1, MA, 16'h0011}, '{FW, 1, CF, 16'h0000}, '{DN, 8, CF, 16'h0028},
    '{FW, 1, PR, 16'h0000}, '{DN, 1, PR, 16'h0011}, '{FW, 1, ED, 16'h000A},
    '{FW, 3, ED, 16'hC00A}, '{DN, 1, ED, 16'hC009}, '{UP, 3, ED, 16'hC00C},
    '{BK, 1, ED, 16'h800C}, '{DN, 2, ED, 16'hA708}, '{UP, 1, ED, 16'h8002},
    '{FW, 1, ED, 16'hC002}, '{FW, 1, PR, 16'h0011}, '{BK, 1, CF, 16'h0028},
    '{FW, 1, PR, 16'h0000}, '{FW, 1, PR, 16'h0000}, '{BK, 3, MN, 16'h0000},
    '{DN, 9, MN, 16'h001C}, '{FW, 3, MN, 16'h0003}, '{FW, 1, MA, 16'h0000}};

  fpm_panel_model #(.DEB_CYC(DEB)) fpm_panel_model_i (
    .i_clk_sys(clk_sys), .o_btn_back(b_back), .o_btn_up(b_up), .o_btn_down(b_down),
    .o_btn_fwd(b_fwd));

  fpm_front_panel #(.MS_CYC(MS), .DEB_CYC(DEB)) fpm_front_panel_i (
    .i_clk_sys(clk_sys), .i_rst(rst), .i_btn_back(b_back), .i_btn_up(b_up),
    .i_btn_down(b_down), .i_btn_fwd(b_fwd), .o_backlight(backlight), .o_screen(screen),
    .o_monitor_mode(monitor_mode), .o_page(page), .o_page_multi(page_multi),
    .o_corner(corner), .o_list_idx(list_idx), .o_list_row(list_row),
    .o_menu_cursor(menu_cursor), .o_marker_row(marker_row), .o_scroll_show(scroll_show),
    .o_edit_active(edit_active), .o_edit_digit(edit_digit), .o_edit_part(edit_part),
    .o_edit_val(edit_val),
    .o_cycle_delay(cycle_delay), .o_cycle_resume(cycle_resume));

  task automatic end_of_test;
    $display("Comparisons %0d mismatches %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wait_page(input logic [3:0] pg, input int lim);
    int k = 0;
    while (page !== pg && k < lim)
    begin
      @(negedge clk_sys);
      k++;
    end
    chk("page_wait", 16'(pg), 16'(page));
    if (page !== pg)
      end_of_test;
  endtask

  initial
  begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  initial
  begin
    rst = 1'b1;
    repeat (20) @(negedge clk_sys);
    chk("bl_reset", 16'h0000, 16'(backlight));
    chk("mode_reset", 16'(fpm_pkg::MON_CYCLE), 16'(monitor_mode));
    chk("delay_reset", 16'(fpm_pkg::CYC_S_DEF), 16'(cycle_delay));
    chk("resume_reset", 16'(fpm_pkg::HOLD_S_DEF), 16'(cycle_resume));
    rst = 1'b0;
    repeat (9 * SEC) @(negedge clk_sys);
    chk("page_dwell", 16'h0000, 16'(page));
    wait_page(4'h1, 2 * SEC);
    $display("Dwell test done");
    fpm_panel_model_i.press(DN, 1);
    chk("page_dn", 16'h0002, 16'(page));
    chk("corner_pf", 16'(fpm_pkg::CRN_PF), 16'(corner));
    chk("backlight", 16'h0001, 16'(backlight));
    fpm_panel_model_i.press(DN, 1);
    chk("corner_freq", 16'(fpm_pkg::CRN_FREQ), 16'(corner));
    fpm_panel_model_i.press(DN, 3);
    chk("corner_angle", 16'(fpm_pkg::CRN_ANGLE), 16'(corner));
    chk("multi", 16'h0001, 16'(page_multi));
    fpm_panel_model_i.press(UP, 1);
    repeat (25 * SEC) @(negedge clk_sys);
    chk("page_hold", 16'h0005, 16'(page));
    $display("Page step test done");
    foreach (rows[i])
    begin
      fpm_panel_model_i.press(rows[i].b, rows[i].n);
      chk("screen", 16'(rows[i].s), 16'(screen));
      chk("edit_active", 16'(rows[i].s == ED), 16'(edit_active));
      if (rows[i].s == ED)
        chk("edit", rows[i].v, {edit_digit, edit_val});
      else if (rows[i].s == MN)
        chk("list", rows[i].v, 16'({list_row, list_idx}));
      else
      begin
        chk("cursor", rows[i].v, 16'({marker_row, menu_cursor}));
        chk("scroll", 16'(rows[i].s != MA), 16'(scroll_show));
      end
      $display("Row %0d done", i);
    end
    chk("mode_list", 16'(fpm_pkg::MON_LIST), 16'(monitor_mode));
    chk("delay_saved", 16'h0002, 16'(cycle_delay));
    $display("Menu test done");
    fpm_panel_model_i.press(DN, 1);
    fpm_panel_model_i.press(FW, 1);
    fpm_panel_model_i.press(DN, 8);
    fpm_panel_model_i.press(FW, 1);
    fpm_panel_model_i.press(DN, 3);
    fpm_panel_model_i.press(FW, 5);
    chk("part_screen", 16'(ED), 16'(screen));
    chk("part", 16'h0001, 16'(edit_part));
    chk("part_val", 16'(fpm_pkg::TIME_DEF), 16'(edit_val));
    fpm_panel_model_i.press(FW, 8);
    chk("part_done", 16'(PR), 16'(screen));
    $display("Multi-part test done");
    rst = 1'b1;
    repeat (2) @(negedge clk_sys);
    rst = 1'b0;
    chk("screen_reset", 16'(MN), 16'(screen));
    chk("mode_reset2", 16'(fpm_pkg::MON_CYCLE), 16'(monitor_mode));
    chk("delay_reset2", 16'(fpm_pkg::CYC_S_DEF), 16'(cycle_delay));
    chk("bl_reset2", 16'h0000, 16'(backlight));
    $display("Reset test done");
    end_of_test;
  end
endmodule

// ===== tb/fpm_panel_model.sv
// Behavioural model of the four front push buttons, with contact bounce.
`timescale 1ns/1ps
module fpm_panel_model #(
  parameter int DEB_CYC = 4
) (
  input wire logic i_clk_sys,
  output logic o_btn_back,
  output logic o_btn_up,
  output logic o_btn_down,
  output logic o_btn_fwd
);
  logic [3:0] lvl = 4'h0;
  // Buttons sit back, up, down and forward from left to right.
  assign {o_btn_fwd, o_btn_down, o_btn_up, o_btn_back} = lvl;
  // Each press bounces once, shorter than the debounce time, then holds.
  task automatic press(input int b, input int n);
    repeat (n)
    begin
      @(negedge i_clk_sys) lvl[b] = 1'b1;
      @(negedge i_clk_sys) lvl[b] = 1'b0;
      @(negedge i_clk_sys) lvl[b] = 1'b1;
      repeat (DEB_CYC + 6) @(negedge i_clk_sys);
      lvl[b] = 1'b0;
      repeat (DEB_CYC + 8) @(negedge i_clk_sys);
    end
  endtask
endmodule
